//--- rtl/bgp_pkg.sv
package bgp_pkg;

	// =====================================================================
	// Geometry
	localparam int unsigned PORT_COUNT = 2;
	localparam int unsigned PORT_WIDTH = 8;
	localparam int unsigned PIN_COUNT  = PORT_COUNT * PORT_WIDTH;
	localparam int unsigned ADDR_WIDTH = 4;

	// =====================================================================
	// Register map
	// Each port owns three consecutive locations starting at its base.
	localparam logic [ADDR_WIDTH-1:0] PORT_STRIDE  = 4'h3;
	localparam logic [ADDR_WIDTH-1:0] OFS_DRIVE    = 4'h0;
	localparam logic [ADDR_WIDTH-1:0] OFS_DIR      = 4'h1;
	localparam logic [ADDR_WIDTH-1:0] OFS_SAMPLE   = 4'h2;
	localparam logic [ADDR_WIDTH-1:0] ADDR_MCU_CTL = 4'hF;

	// Field position of the global pull-up disable in the control register.
	localparam int unsigned BIT_PULLUP_DISABLE = 0;

	// =====================================================================
	// Reset values
	localparam logic [PORT_WIDTH-1:0] RST_DRIVE  = 8'h00;
	localparam logic [PORT_WIDTH-1:0] RST_DIR    = 8'h00;
	localparam logic [PORT_WIDTH-1:0] RST_SAMPLE = 8'h00;
	localparam logic                  RST_NOPULL = 1'h0;
	localparam logic [PORT_WIDTH-1:0] READ_IDLE  = 8'h00;

	// =====================================================================
	// Register kinds seen by the decoder
	typedef enum logic [2:0] {
		KIND_DRIVE,
		KIND_DIR,
		KIND_SAMPLE,
		KIND_CTRL,
		KIND_NONE
	} bgp_kind_t;

endpackage

//--- rtl/bgp_sync_if.sv
interface bgp_sync_if;

	// =====================================================================
	// Raw pin levels in, qualified levels out, one port wide.
	logic [bgp_pkg::PORT_WIDTH-1:0] raw;
	logic [bgp_pkg::PORT_WIDTH-1:0] level;

	modport sync (
		input  raw,
		output level
	);

	modport user (
		output raw,
		input  level
	);

endinterface

//--- rtl/bgp_input_sync.sv
module bgp_input_sync (
	input  wire logic clk,
	input  wire logic resetn,
	bgp_sync_if.sync  port
);

	// =====================================================================
	// Three-stage capture
	// The first stage may go metastable, so only the second stage reads it.
	logic [bgp_pkg::PORT_WIDTH-1:0] stage1;
	logic [bgp_pkg::PORT_WIDTH-1:0] stage2;
	logic [bgp_pkg::PORT_WIDTH-1:0] stage3;
	logic [bgp_pkg::PORT_WIDTH-1:0] level;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			stage1 <= bgp_pkg::RST_SAMPLE;
			stage2 <= bgp_pkg::RST_SAMPLE;
			stage3 <= bgp_pkg::RST_SAMPLE;
		end else begin
			stage1 <= port.raw;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// =====================================================================
	// Qualification
	// A bit takes a new level only once the last two stages agree.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			level <= bgp_pkg::RST_SAMPLE;
		end else begin
			for (int i = 0; i < bgp_pkg::PORT_WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					level[i] <= stage3[i];
				end
			end
		end
	end

	assign port.level = level;

endmodule

//--- rtl/bgp_gpio_port.sv
// Functional notes
// - Direction bit one makes the pin an output, zero an input.
// - Input with drive value one enables its pull-up, otherwise off.
// - During reset every pin floats, even with no clock running.
// - Output pins drive high for drive value one, low for zero.
// - Writing one to a sampled-level bit inverts that drive value bit.
// - Per port: drive value and direction read/write, sampled level read.
// - Global pull-up disable switches off pull-ups on every pin.
// - Changing one bit leaves every other pin of the port untouched.
// - After reset direction and drive value are zero: floating input.
// - Alternate function on some pins leaves the others as plain I/O.
// - Sampled level shows the pin itself in input and output modes.
// - Pin level reaches the sampled-level register through a synchroniser.
//
// The address-and-strobe port and the register addresses were decided locally.
module bgp_gpio_port (
	input  wire logic                                  clk,
	input  wire logic                                  resetn,
	input  wire logic [bgp_pkg::ADDR_WIDTH-1:0]        regAddr,
	input  wire logic [bgp_pkg::PORT_WIDTH-1:0]        regWdata,
	input  wire logic                                  regWrite,
	input  wire logic                                  regRead,
	output      logic [bgp_pkg::PORT_WIDTH-1:0]        regRdata,
	input  wire logic [bgp_pkg::PIN_COUNT-1:0]         pinIn,
	output      logic [bgp_pkg::PIN_COUNT-1:0]         pinOut,
	output      logic [bgp_pkg::PIN_COUNT-1:0]         pinOe,
	output      logic [bgp_pkg::PIN_COUNT-1:0]         pinPullup,
	input  wire logic [bgp_pkg::PIN_COUNT-1:0]         altEnable,
	input  wire logic [bgp_pkg::PIN_COUNT-1:0]         altOe,
	input  wire logic [bgp_pkg::PIN_COUNT-1:0]         altOut,
	output      logic                                  globalPullupDisable
);

	localparam int unsigned NP = bgp_pkg::PORT_COUNT;
	localparam int unsigned NW = bgp_pkg::PORT_WIDTH;

	// =====================================================================
	// Address decoding
	// Used by the write path and the read path alike.
	function automatic bgp_pkg::bgp_kind_t decodeKind(
		input logic [bgp_pkg::ADDR_WIDTH-1:0] addr
	);
		logic [bgp_pkg::ADDR_WIDTH-1:0] base;
		decodeKind = bgp_pkg::KIND_NONE;
		if (addr == bgp_pkg::ADDR_MCU_CTL) begin
			decodeKind = bgp_pkg::KIND_CTRL;
		end
		for (int p = 0; p < NP; p++) begin
			base = bgp_pkg::ADDR_WIDTH'(p * int'(bgp_pkg::PORT_STRIDE));
			if (addr == base + bgp_pkg::OFS_DRIVE) begin
				decodeKind = bgp_pkg::KIND_DRIVE;
			end
			if (addr == base + bgp_pkg::OFS_DIR) begin
				decodeKind = bgp_pkg::KIND_DIR;
			end
			if (addr == base + bgp_pkg::OFS_SAMPLE) begin
				decodeKind = bgp_pkg::KIND_SAMPLE;
			end
		end
	endfunction

	// Port index of a port location; meaningless for other kinds.
	function automatic int unsigned decodePort(
		input logic [bgp_pkg::ADDR_WIDTH-1:0] addr
	);
		logic [bgp_pkg::ADDR_WIDTH-1:0] base;
		decodePort = 0;
		for (int p = 0; p < NP; p++) begin
			base = bgp_pkg::ADDR_WIDTH'(p * int'(bgp_pkg::PORT_STRIDE));
			if (addr >= base && addr < base + bgp_pkg::PORT_STRIDE) begin
				decodePort = p;
			end
		end
	endfunction

	bgp_pkg::bgp_kind_t wrKind;
	bgp_pkg::bgp_kind_t rdKind;
	int unsigned        wrPort;
	int unsigned        rdPort;

	always_comb begin
		wrKind = decodeKind(regAddr);
		rdKind = decodeKind(regAddr);
		wrPort = decodePort(regAddr);
		rdPort = decodePort(regAddr);
	end

	// =====================================================================
	// Control register
	logic pullupDisable;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pullupDisable <= bgp_pkg::RST_NOPULL;
		end else if (regWrite && wrKind == bgp_pkg::KIND_CTRL) begin
			pullupDisable <= regWdata[bgp_pkg::BIT_PULLUP_DISABLE];
		end
	end

	assign globalPullupDisable = pullupDisable;

	// =====================================================================
	// Per-port registers and pin logic
	logic [NW-1:0] driveValue [NP];
	logic [NW-1:0] direction  [NP];
	logic [NW-1:0] sampled    [NP];

	generate
		for (genvar p = 0; p < NP; p++) begin : g_port
			bgp_sync_if syncBus ();

			logic wrDrive;
			logic wrDir;
			logic wrToggle;

			assign wrDrive  = regWrite && wrPort == p
				&& wrKind == bgp_pkg::KIND_DRIVE;
			assign wrDir    = regWrite && wrPort == p
				&& wrKind == bgp_pkg::KIND_DIR;
			assign wrToggle = regWrite && wrPort == p
				&& wrKind == bgp_pkg::KIND_SAMPLE;

			// Whole-byte write; bits written back unchanged stay put,
			// so a read-modify-write of one bit touches only that pin.
			always_ff @(posedge clk) begin
				if (!resetn) begin
					direction[p] <= bgp_pkg::RST_DIR;
				end else if (wrDir) begin
					direction[p] <= regWdata;
				end
			end

			// A toggle write flips drive bits whatever the direction,
			// and zeros in the written byte leave their bits alone.
			always_ff @(posedge clk) begin
				if (!resetn) begin
					driveValue[p] <= bgp_pkg::RST_DRIVE;
				end else if (wrDrive) begin
					driveValue[p] <= regWdata;
				end else if (wrToggle) begin
					driveValue[p] <= driveValue[p] ^ regWdata;
				end
			end

			// The pad level is watched in every mode, so an output pin
			// held against a strong external load reads what it really is.
			assign syncBus.raw = pinIn[p*NW +: NW];

			bgp_input_sync u_sync (
				.clk    (clk),
				.resetn (resetn),
				.port   (syncBus.sync)
			);

			assign sampled[p] = syncBus.level;

			for (genvar n = 0; n < NW; n++) begin : g_pin
				localparam int unsigned IDX = p * NW + n;

				logic gpioOe;
				logic gpioPull;

				assign gpioOe   = direction[p][n];
				assign gpioPull = !direction[p][n]
					&& driveValue[p][n]
					&& !pullupDisable;

				// Reset gates the pads combinationally so they float at
				// once, without waiting for a clock edge.
				always_comb begin
					if (!resetn) begin
						pinOe[IDX]     = 1'h0;
						pinPullup[IDX] = 1'h0;
						pinOut[IDX]    = 1'h0;
					end else if (altEnable[IDX]) begin
						pinOe[IDX]     = altOe[IDX];
						pinPullup[IDX] = 1'h0;
						pinOut[IDX]    = altOut[IDX];
					end else begin
						pinOe[IDX]     = gpioOe;
						pinPullup[IDX] = gpioPull;
						pinOut[IDX]    = driveValue[p][n];
					end
				end
			end
		end
	endgenerate

	// =====================================================================
	// Read path
	// Data stand only in the cycle after the read strobe; the sampled
	// location is read-only, its write side effect being the toggle above.
	logic [NW-1:0] readValue;

	always_comb begin
		readValue = bgp_pkg::READ_IDLE;
		unique case (rdKind)
			bgp_pkg::KIND_DRIVE:  readValue = driveValue[rdPort];
			bgp_pkg::KIND_DIR:    readValue = direction[rdPort];
			bgp_pkg::KIND_SAMPLE: readValue = sampled[rdPort];
			bgp_pkg::KIND_CTRL: begin
				readValue[bgp_pkg::BIT_PULLUP_DISABLE] = pullupDisable;
			end
			bgp_pkg::KIND_NONE:   readValue = bgp_pkg::READ_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			regRdata <= bgp_pkg::READ_IDLE;
		end else if (regRead) begin
			regRdata <= readValue;
		end else begin
			regRdata <= bgp_pkg::READ_IDLE;
		end
	end

endmodule

//--- bench/bgp_gpio_port_chk.sv
module bgp_gpio_port_chk (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [3:0]  regAddr,
	input wire logic [7:0]  regWdata,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [7:0]  regRdata,
	input wire logic [15:0] pinIn,
	input wire logic [15:0] pinOut,
	input wire logic [15:0] pinOe,
	input wire logic [15:0] pinPullup,
	input wire logic [15:0] altEnable,
	input wire logic [15:0] altOe,
	input wire logic [15:0] altOut,
	input wire logic        globalPullupDisable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// Reset must float the pins, so this one is not disabled by reset.
	a_reset_float: assert property (disable iff (1'b0)
		!resetn |-> pinOe == 16'h0000 && pinPullup == 16'h0000)
		else $error("pins driven in reset");
	a_dir_to_oe: assert property (
		regWrite && regAddr == 4'h1 |=>
		|altEnable[7:0] || pinOe[7:0] == $past(regWdata))
		else $error("direction not on enables");
	a_pullup_eq: assert property (
		pinPullup == (~pinOe & pinOut & ~altEnable
		& {16{!globalPullupDisable}}))
		else $error("pull-up wrong");
	a_toggle_bits: assert property (
		regWrite && regAddr == 4'h2 && altEnable[7:0] == 8'h00 |=>
		pinOut[7:0] == ($past(pinOut[7:0]) ^ $past(regWdata)))
		else $error("toggle wrong");
	a_read_dir: assert property (
		regRead && regAddr == 4'h1 && altEnable[7:0] == 8'h00 |=>
		regRdata == $past(pinOe[7:0]))
		else $error("direction readback wrong");
	a_rdata_idle: assert property (
		!regRead |=> regRdata == 8'h00)
		else $error("read data without read");
	a_others_kept: assert property (
		regWrite && regAddr < 4'h3 |=> !$stable(altEnable)
		|| $stable(pinOe[15:8]) && $stable(pinOut[15:8]))
		else $error("other port disturbed");
	a_sample_lag: assert property (
		$stable(pinIn[7:0]) [*5] ##0 (regRead && regAddr == 4'h2)
		|=> regRdata == $past(pinIn[7:0]))
		else $error("sampled level wrong");
	a_alt_wins: assert property (
		(pinOe & altEnable) == (altOe & altEnable)
		&& (pinOut & altEnable) == (altOut & altEnable))
		else $error("alternate override wrong");
	c_toggle: cover property (regWrite && regAddr == 4'h2);
	c_alt: cover property (|altEnable);
	c_pull_off: cover property (globalPullupDisable);
endmodule

bind bgp_gpio_port bgp_gpio_port_chk u_bgp_gpio_port_chk (.clk, .resetn,
	.regAddr, .regWdata, .regWrite, .regRead, .regRdata, .pinIn, .pinOut,
	.pinOe, .pinPullup, .altEnable, .altOe, .altOut, .globalPullupDisable);

//--- bench/bgp_pad_model.sv
module bgp_pad_model (
	input  wire logic        clk,
	input  wire logic [15:0] pinOe,
	input  wire logic [15:0] pinOut,
	input  wire logic [15:0] pinPullup,
	input  wire logic [15:0] extEn,
	input  wire logic [15:0] extVal,
	output      logic [15:0] pinLevel
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] lastLevel = 16'h0000;
	always @(posedge clk) lastLevel <= pinLevel;
	// A floating pad flips every cycle so nobody can rely on its value.
	always_comb pinLevel = (pinOe & pinOut) | (~pinOe & extEn & extVal)
		| (~pinOe & ~extEn & (pinPullup | ~lastLevel));
endmodule

//--- bench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [7:0]  regWdata = 8'h00;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [7:0]  regRdata;
	logic [15:0] pinLevel, pinOut, pinOe, pinPullup;
	logic [15:0] altEnable = 16'h0000;
	logic [15:0] altOe = 16'h0000;
	logic [15:0] altOut = 16'h0000;
	logic [15:0] extEn = 16'h0000;
	logic [15:0] extVal = 16'h0000;
	logic        globalPullupDisable;
	int          num_errors = 0;
	int          num_checks = 0;
	always #20 clk = ~clk;
	bgp_gpio_port u_bgp_gpio_port (.clk, .resetn, .regAddr, .regWdata,
		.regWrite, .regRead, .regRdata, .pinIn(pinLevel), .pinOut, .pinOe,
		.pinPullup, .altEnable, .altOe, .altOut, .globalPullupDisable);
	bgp_pad_model u_bgp_pad_model (.clk, .pinOe, .pinOut, .pinPullup,
		.extEn, .extVal, .pinLevel);

	// ==================================================================
	// Bus and compare tasks
	task automatic chk(input string name, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		#1;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), {8'h00, regRdata}, {8'h00, exp});
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==================================================================
	// Scenarios
	task automatic s_config;
		@(posedge clk);
		extEn <= 16'h00F0;
		extVal <= 16'h00C0;
		wr(4'h0, 8'h33);
		wr(4'h1, 8'h0F);
		chk("oe", pinOe, 16'h000F);
		chk("out", pinOut & pinOe, 16'h0003);
		chk("pull", pinPullup, 16'h0030);
		repeat (4) @(posedge clk);
		rdchk(4'h2, 8'hC3);
		rdchk(4'h1, 8'h0F);
		wr(4'h2, 8'h00);
		rdchk(4'h0, 8'h33);
		wr(4'h2, 8'h81);
		rdchk(4'h0, 8'hB2);
		wr(4'h2, 8'h81);
		wr(4'h1, 8'h1F);
		chk("oe", pinOe, 16'h001F);
		chk("pull", pinPullup, 16'h0020);
		wr(4'h1, 8'h0F);
	endtask
	task automatic s_pullup_off;
		wr(4'h3, 8'hFF);
		chk("pull", pinPullup, 16'hFF30);
		repeat (4) @(posedge clk);
		rdchk(4'h5, 8'hFF);
		wr(4'hF, 8'h01);
		chk("pull", pinPullup, 16'h0000);
		chk("pullOff", globalPullupDisable, 16'h0001);
		rdchk(4'hF, 8'h01);
		wr(4'hF, 8'h00);
		chk("pullOff", globalPullupDisable, 16'h0000);
		chk("pull", pinPullup, 16'hFF30);
		wr(4'h9, 8'hFF);
		rdchk(4'h9, 8'h00);
		rdchk(4'h0, 8'h33);
	endtask
	task automatic s_switch;
		wr(4'h4, 8'h01);
		chk("p8", {pinOe[8], pinOut[8], pinPullup[8]}, 3'b110);
		wr(4'h3, 8'hFE);
		chk("p8", {pinOe[8], pinOut[8], pinPullup[8]}, 3'b100);
		wr(4'h4, 8'h00);
		chk("p8", {pinOe[8], pinOut[8], pinPullup[8]}, 3'b000);
		wr(4'h3, 8'hFF);
		chk("p8", {pinOe[8], pinOut[8], pinPullup[8]}, 3'b011);
	endtask
	task automatic s_alt;
		@(posedge clk);
		altEnable <= 16'h0001;
		@(posedge clk);
		#1;
		chk("oe", pinOe, 16'h000E);
		chk("out", pinOut, 16'hFF32);
		chk("pull", pinPullup, 16'hFF30);
		@(posedge clk);
		altEnable <= 16'h0000;
	endtask
	task automatic s_reset;
		@(posedge clk);
		resetn <= 1'b0;
		#1;
		chk("oe", pinOe, 16'h0000);
		chk("pull", pinPullup, 16'h0000);
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rdchk(4'h1, 8'h00);
		rdchk(4'h3, 8'h00);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		stop_test;
	end
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rdchk(4'h0, 8'h00);
		s_config;
		s_pullup_off;
		s_switch;
		s_alt;
		s_reset;
		stop_test;
	end
endmodule
